//--- inc/dib_consts.svh
// offsets, field positions, reset values and codes of the brake and i/o block
`ifndef DIB_CONSTS_SVH
`define DIB_CONSTS_SVH
`define DIB_ADR_SVF5_A 8'h00
`define DIB_ADR_SVF5_B 8'h04
`define DIB_ADR_SVS2_A 8'h08
`define DIB_ADR_SVS2_B 8'h0C
`define DIB_ADR_SPF7 8'h10
`define DIB_ADR_SPF5 8'h14
`define DIB_ADR_STAT 8'h18
`define DIB_ADR_EVT 8'h1C
`define DIB_REG_RST 16'h0000
`define DIB_OUTPUT_THREE_SELECT_HI 11
`define DIB_OUTPUT_THREE_SELECT_LO 10
`define DIB_OUTPUT_THREE_SELECT_OFF 2'h0
`define DIB_OUTPUT_THREE_SELECT_CONT 2'h2
`define DIB_CBC_BIT 8
`define DIB_DIS_HI 15
`define DIB_DIS_LO 12
`define DIB_DIS_NONE 4'h0
`define DIB_DIS_PROX 4'h4
`define DIB_DDIR_BIT 5
`define DIB_ALARM_INIT_PARAM 8'h37
`define DIB_ALARM_NONE 8'h00
`endif

//--- inc/dib_pkg.sv
// types shared by the brake and i/o block
package dib_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dib_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dib_wb_rsp_t;
  typedef enum logic [1:0] {
    DIB_BRK_ALL = 2'b00,
    DIB_BRK_ONE_A = 2'b01,
    DIB_BRK_ONE_B = 2'b10,
    DIB_BRK_FAULT = 2'b11
  } dib_brk_mode_t;
  typedef enum logic [3:0] {
    DIB_R_SVF5_A = 4'h0,
    DIB_R_SVF5_B = 4'h1,
    DIB_R_SVS2_A = 4'h2,
    DIB_R_SVS2_B = 4'h3,
    DIB_R_SPF7 = 4'h4,
    DIB_R_SPF5 = 4'h5,
    DIB_R_STAT = 4'h6,
    DIB_R_EVT = 4'h7,
    DIB_R_NONE = 4'hF
  } dib_reg_t;
endpackage

//--- hdl/dib_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dib_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin side and synchronised side
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  if (W < 1) begin : g_width_check
    $error("dib_sync: width must be positive");
  end
  // reset value comes in as a constant tie from the parent
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= rst_val_i;
      sync_o <= rst_val_i;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // dib_sync

//--- hdl/dib_top.sv
// brake release, contactor output and proximity input logic of a two-axis drive
// How it works
// - output-3 field 00 disables, 10 drives contactor, 01 and 11 prohibited
// - without SPINDLE both axes must hold the same output-3 selection for the shared pin
// - brake released only while a motor is energised and producing torque
// - brake-axis bit lets one axis rule brake; set on all gives alarm 37
// - servo off engages brake on the very edge the motor is de-energised
// - drop prevention only in emergency, alarm or power failure, never servo off
// - without axis selection the brake engages only when all axes are off
// - emergency stop forces servo off on every axis at once
// - after emergency cancel the brake releases only once motor power is up
// - proximity edge bit: 0 falling edge, 1 rising edge
// - spindle input field 0 unused, 4 proximity switch, others prohibited
`timescale 1ns/1ps
`include "dib_consts.svh"
module dib_top #(
  parameter int AXES = 2,
  parameter bit SPINDLE = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire dib_pkg::dib_wb_req_t wb_req_i,
  output dib_pkg::dib_wb_rsp_t wb_rsp_o,
  // numerical control and power stage
  input wire logic [1:0] servo_on_cmd_i,
  input wire logic [1:0] motor_power_on_i,
  input wire logic drive_alarm_i,
  input wire logic power_fail_i,
  // pins
  input wire logic external_emergency_stop_in_n_i,
  input wire logic prox_switch_i,
  // drive outputs
  output logic [1:0] servo_en_o,
  output logic [1:0] drop_prevent_o,
  output logic brake_relay_out_a_o,
  output logic brake_relay_out_b_o,
  output logic contactor_ctrl_out_o,
  output logic prox_detect_o,
  output logic [7:0] alarm_code_o
);
  if (AXES != 2) begin : g_axes_check
    $error("dib_top: only two-axis units are served");
  end

  logic [15:0] svf5_r [2];
  logic [15:0] svs2_r [2];
  logic [15:0] spf7_r;
  logic [15:0] spf5_r;
  logic prox_evt_r;
  logic prox_last_r;
  logic [1:0] motor_on_r;
  logic brake_rel_r;
  logic [1:0] pins_s;
  logic ack_r;

  function automatic dib_pkg::dib_reg_t adr_dec(input logic [7:0] a);
    if (a == `DIB_ADR_SVF5_A) adr_dec = dib_pkg::DIB_R_SVF5_A;
    else if (a == `DIB_ADR_SVF5_B) adr_dec = dib_pkg::DIB_R_SVF5_B;
    else if (a == `DIB_ADR_SVS2_A) adr_dec = dib_pkg::DIB_R_SVS2_A;
    else if (a == `DIB_ADR_SVS2_B) adr_dec = dib_pkg::DIB_R_SVS2_B;
    else if (a == `DIB_ADR_SPF7) adr_dec = dib_pkg::DIB_R_SPF7;
    else if (a == `DIB_ADR_SPF5) adr_dec = dib_pkg::DIB_R_SPF5;
    else if (a == `DIB_ADR_STAT) adr_dec = dib_pkg::DIB_R_STAT;
    else if (a == `DIB_ADR_EVT) adr_dec = dib_pkg::DIB_R_EVT;
    else adr_dec = dib_pkg::DIB_R_NONE;
  endfunction

  // byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // pins cross into the clock domain first
  dib_sync #(.W(2)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({external_emergency_stop_in_n_i, prox_switch_i}),
    .rst_val_i(2'b00),
    .sync_o(pins_s)
  );
  // estop pin reads low after reset until the first samples arrive: safe side
  wire estop_w = ~pins_s[1];
  wire prox_w = pins_s[0];

  // bus decode
  wire req_w = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
  wire wr_w = req_w & wb_req_i.we;
  dib_pkg::dib_reg_t rsel_w;
  assign rsel_w = adr_dec(wb_req_i.adr);

  // parameter fields
  wire [1:0] output_three_select_a_w = SPINDLE ? spf7_r[`DIB_OUTPUT_THREE_SELECT_HI:`DIB_OUTPUT_THREE_SELECT_LO] : svf5_r[0][`DIB_OUTPUT_THREE_SELECT_HI:`DIB_OUTPUT_THREE_SELECT_LO];
  wire [1:0] output_three_select_b_w = svf5_r[1][`DIB_OUTPUT_THREE_SELECT_HI:`DIB_OUTPUT_THREE_SELECT_LO];
  wire output_three_select_mismatch_w = ~SPINDLE & (output_three_select_a_w != output_three_select_b_w);
  wire output_three_select_prohib_w = (output_three_select_a_w != `DIB_OUTPUT_THREE_SELECT_OFF) && (output_three_select_a_w != `DIB_OUTPUT_THREE_SELECT_CONT);
  wire cont_sel_w = (output_three_select_a_w == `DIB_OUTPUT_THREE_SELECT_CONT) & ~output_three_select_mismatch_w;
  wire [3:0] dis_w = spf7_r[`DIB_DIS_HI:`DIB_DIS_LO];
  wire prox_en_w = dis_w == `DIB_DIS_PROX;
  wire dis_prohib_w = (dis_w != `DIB_DIS_NONE) && !prox_en_w;
  wire [1:0] cbc_w = {svs2_r[1][`DIB_CBC_BIT], svs2_r[0][`DIB_CBC_BIT]};
  wire alarm37_w = &cbc_w;

  // brake mode from axis selection
  dib_pkg::dib_brk_mode_t brk_mode_w;
  assign brk_mode_w = dib_pkg::dib_brk_mode_t'(cbc_w);

  // emergency covers the pin, drive alarms, power loss and parameter error
  wire emerg_w = estop_w | drive_alarm_i | power_fail_i | alarm37_w;
  wire [1:0] servo_en_nxt = emerg_w ? 2'b00 : servo_on_cmd_i;
  // drop prevention keeps torque up only on the emergency path, never on servo off
  wire [1:0] drop_prevent_nxt = emerg_w ? (motor_on_r & motor_power_on_i) : 2'b00;
  // torque exists only once the power stage reports power
  wire [1:0] motor_on_nxt = (servo_en_nxt | drop_prevent_nxt) & motor_power_on_i;
  logic brake_rel_nxt;
  always_comb begin
    case (brk_mode_w)
      dib_pkg::DIB_BRK_ALL: brake_rel_nxt = |motor_on_nxt;
      dib_pkg::DIB_BRK_ONE_A: brake_rel_nxt = motor_on_nxt[0];
      dib_pkg::DIB_BRK_ONE_B: brake_rel_nxt = motor_on_nxt[1];
      default: brake_rel_nxt = 1'b0;
    endcase
  end
  wire contactor_nxt = cont_sel_w & ~emerg_w;

  // proximity edge on the selected polarity
  wire prox_edge_w = spf5_r[`DIB_DDIR_BIT] ? (prox_w & ~prox_last_r) : (~prox_w & prox_last_r);
  wire prox_hit_w = prox_en_w & prox_edge_w;
  wire evt_clr_w = wr_w & (rsel_w == dib_pkg::DIB_R_EVT) & wb_req_i.sel[0] & wb_req_i.dat[0];

  wire [15:0] stat_w = {7'h00, dis_prohib_w, output_three_select_mismatch_w, output_three_select_prohib_w, alarm37_w,
                        estop_w, brake_rel_r, contactor_ctrl_out_o, motor_on_r};
  logic [15:0] rd_w;
  always_comb begin
    case (rsel_w)
      dib_pkg::DIB_R_SVF5_A: rd_w = svf5_r[0];
      dib_pkg::DIB_R_SVF5_B: rd_w = svf5_r[1];
      dib_pkg::DIB_R_SVS2_A: rd_w = svs2_r[0];
      dib_pkg::DIB_R_SVS2_B: rd_w = svs2_r[1];
      dib_pkg::DIB_R_SPF7: rd_w = spf7_r;
      dib_pkg::DIB_R_SPF5: rd_w = spf5_r;
      dib_pkg::DIB_R_STAT: rd_w = stat_w;
      dib_pkg::DIB_R_EVT: rd_w = {15'h0000, prox_evt_r};
      default: rd_w = 16'h0000;
    endcase
  end

  // bus slave: one wait state, unmapped reads zero and writes drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_rsp_o <= '0;
    end else begin
      ack_r <= req_w;
      wb_rsp_o.ack <= req_w;
      wb_rsp_o.dat <= req_w ? {16'h0000, rd_w} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      svf5_r[0] <= `DIB_REG_RST;
      svf5_r[1] <= `DIB_REG_RST;
      svs2_r[0] <= `DIB_REG_RST;
      svs2_r[1] <= `DIB_REG_RST;
      spf7_r <= `DIB_REG_RST;
      spf5_r <= `DIB_REG_RST;
    end else if (wr_w) begin
      if (rsel_w == dib_pkg::DIB_R_SVF5_A) svf5_r[0] <= wr16(svf5_r[0], wb_req_i.dat, wb_req_i.sel);
      if (rsel_w == dib_pkg::DIB_R_SVF5_B) svf5_r[1] <= wr16(svf5_r[1], wb_req_i.dat, wb_req_i.sel);
      if (rsel_w == dib_pkg::DIB_R_SVS2_A) svs2_r[0] <= wr16(svs2_r[0], wb_req_i.dat, wb_req_i.sel);
      if (rsel_w == dib_pkg::DIB_R_SVS2_B) svs2_r[1] <= wr16(svs2_r[1], wb_req_i.dat, wb_req_i.sel);
      if (rsel_w == dib_pkg::DIB_R_SPF7) spf7_r <= wr16(spf7_r, wb_req_i.dat, wb_req_i.sel);
      if (rsel_w == dib_pkg::DIB_R_SPF5) spf5_r <= wr16(spf5_r, wb_req_i.dat, wb_req_i.sel);
    end
  end

  // servo enable and brake change on the same edge, so no gap opens between them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_en_o <= 2'b00;
      drop_prevent_o <= 2'b00;
      motor_on_r <= 2'b00;
      brake_rel_r <= 1'b0;
      brake_relay_out_a_o <= 1'b0;
      brake_relay_out_b_o <= 1'b0;
      contactor_ctrl_out_o <= 1'b0;
      alarm_code_o <= `DIB_ALARM_NONE;
    end else begin
      servo_en_o <= servo_en_nxt;
      drop_prevent_o <= drop_prevent_nxt;
      motor_on_r <= motor_on_nxt;
      brake_rel_r <= brake_rel_nxt;
      brake_relay_out_a_o <= brake_rel_nxt;
      brake_relay_out_b_o <= brake_rel_nxt;
      contactor_ctrl_out_o <= contactor_nxt;
      alarm_code_o <= alarm37_w ? `DIB_ALARM_INIT_PARAM : `DIB_ALARM_NONE;
    end
  end

  // sticky event: a new edge wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prox_last_r <= 1'b0;
      prox_evt_r <= 1'b0;
      prox_detect_o <= 1'b0;
    end else begin
      prox_last_r <= prox_w;
      prox_detect_o <= prox_hit_w;
      prox_evt_r <= prox_hit_w | (prox_evt_r & ~evt_clr_w);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_power_up;
    !brake_rel_r ##1 (brake_rel_r && !(|drop_prevent_o));
  endsequence

  contactor_sel_a: assert property (
    contactor_ctrl_out_o |-> $past(output_three_select_a_w) == `DIB_OUTPUT_THREE_SELECT_CONT)
    else $error("contactor driven without select 10");
  pin_match_a: assert property (
    contactor_ctrl_out_o |-> (SPINDLE || $past(output_three_select_b_w) == $past(output_three_select_a_w)))
    else $error("contactor driven with differing axis selections");
  brake_torque_a: assert property (
    brake_rel_r |-> |motor_on_r)
    else $error("brake released without torque");
  alarm_param_a: assert property (
    alarm37_w |=> alarm_code_o == `DIB_ALARM_INIT_PARAM && !brake_relay_out_a_o)
    else $error("all-axis brake selection not flagged");
  servo_off_a: assert property (
    !emerg_w && servo_en_o != 2'b00 && servo_on_cmd_i == 2'b00 |=> !brake_rel_r && servo_en_o == 2'b00)
    else $error("brake late after servo off");
  drop_only_a: assert property (
    |drop_prevent_o |-> $past(emerg_w))
    else $error("drop prevention outside emergency");
  all_axes_a: assert property (
    brk_mode_w == dib_pkg::DIB_BRK_ALL && $rose(motor_on_r[1]) && motor_on_r[0] == 1'b0 |-> brake_rel_r)
    else $error("brake engaged while an axis is on");
  estop_all_a: assert property (
    emerg_w |=> servo_en_o == 2'b00)
    else $error("emergency did not drop all axes");
  cancel_order_a: assert property (
    $rose(brake_rel_r) && !(|drop_prevent_o) |-> $past(|(servo_en_nxt & motor_power_on_i)))
    else $error("brake released before motor power");
  release_seq_a: assert property (
    s_power_up |-> |(servo_en_o & $past(motor_power_on_i)))
    else $error("release without power-up sequence");
  prox_edge_a: assert property (
    prox_en_w && spf5_r[`DIB_DDIR_BIT] && $past(prox_en_w) && !prox_last_r && prox_w |=> prox_detect_o)
    else $error("rising proximity edge missed");
  prox_sel_a: assert property (
    prox_detect_o |-> $past(dis_w) == `DIB_DIS_PROX)
    else $error("proximity detect with input unused");
  cont_idle_a: assert property (
    output_three_select_a_w != `DIB_OUTPUT_THREE_SELECT_CONT |=> !contactor_ctrl_out_o)
    else $error("contactor active while disabled");
endmodule // dib_top

//--- verif/dib_power_model.sv
// power stage model: reports motor energised some cycles after enable
`timescale 1ns/1ps
module dib_power_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // enable from drive, speed of the stage
  input wire logic [1:0] servo_en_i,
  input wire logic slow_i,
  // energised report back to drive
  output logic [1:0] motor_power_on_o
);
  logic [5:0] hist_r;
  // slow stage lags three cycles, so brake release must wait for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_r <= 6'h00;
    end else begin
      hist_r <= {hist_r[3:0], servo_en_i};
    end
  end
  assign motor_power_on_o = slow_i ? hist_r[5:4] : hist_r[1:0];
endmodule // dib_power_model

//--- verif/dib_top_bench.sv
// self-checking bench of the brake and i/o block with its power stage model
`timescale 1ns/1ps
module dib_top_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  dib_pkg::dib_wb_req_t req = '0;
  dib_pkg::dib_wb_rsp_t rsp;
  logic [1:0] cmd = 2'h0;
  logic [1:0] pwr;
  logic estop_n = 1'b1;
  logic prox = 1'b0;
  logic slow = 1'b1;
  logic dalarm = 1'b0;
  logic pfail = 1'b0;
  logic [1:0] en;
  logic [1:0] drop;
  logic brk_a;
  logic brk_b;
  logic cont;
  logic pdet;
  logic [7:0] alarm;
  int n_errors = 0;
  int check_count = 0;
  always #5 clk_i = ~clk_i;
  dib_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .servo_on_cmd_i(cmd),
    .motor_power_on_i(pwr), .drive_alarm_i(dalarm), .power_fail_i(pfail), .external_emergency_stop_in_n_i(estop_n),
    .prox_switch_i(prox), .servo_en_o(en), .drop_prevent_o(drop), .brake_relay_out_a_o(brk_a),
    .brake_relay_out_b_o(brk_b), .contactor_ctrl_out_o(cont), .prox_detect_o(pdet), .alarm_code_o(alarm));
  dib_power_model i_pwr (.clk_i(clk_i), .rst_i(rst_i), .servo_en_i(en), .slow_i(slow), .motor_power_on_o(pwr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // request held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, 1'b1, "bus ack missing");
    rd = rsp.dat;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    wb(1'b1, a, d, dummy);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    wb(1'b0, a, 32'h0000_0000, d);
    chk(d, e, what);
  endtask
  task automatic count(output int c);
    c = 0;
    repeat (8) begin
      @(posedge clk_i);
      if (pdet === 1'b1) c++;
    end
  endtask
  function automatic logic brk_exp(input int s, input logic [1:0] e);
    if (s == 3) return 1'b0;
    if (s == 0) return |e;
    return e[s-1];
  endfunction
  initial begin
    logic [31:0] v;
    logic [1:0] ee;
    int n;
    int nr;
    int nf;
    void'($urandom(20332));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int r = 0; r < 6; r++) rdc(8'(r * 4), 32'h0000_0000, "reset value");
    for (int r = 0; r < 6; r++) begin
      v = $urandom;
      wr(8'(r * 4), v);
      rdc(8'(r * 4), v & 32'h0000_FFFF, "read back");
      wr(8'(r * 4), 32'h0000_0000);
    end
    wr(8'h20, 32'h0000_FFFF);
    rdc(8'h20, 32'h0000_0000, "unmapped read");
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, c << 10);
      wr(8'h04, c << 10);
      repeat (3) @(posedge clk_i);
      chk(cont, c == 2, "contactor select");
      rdc(8'h18, ((c == 2) ? 32'h0000_0004 : 32'h0000_0000) | ((c & 1) ? 32'h0000_0040 : 32'h0000_0000),
        "status select");
    end
    wr(8'h00, 32'h0000_0800);
    wr(8'h04, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk(cont, 1'b0, "axis mismatch");
    rdc(8'h18, 32'h0000_0080, "status mismatch");
    wr(8'h00, 32'h0000_0000);
    $display("test contactor done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h08, (s & 1) << 8);
      wr(8'h0C, (s >> 1) << 8);
      for (int k = 0; k < 4; k++) begin
        slow <= 1'(k & 1);
        cmd <= 2'(k);
        repeat (8) @(posedge clk_i);
        ee = (s == 3) ? 2'h0 : 2'(k);
        chk(en, ee, "servo enable");
        chk(brk_a, brk_exp(s, ee), "brake a");
        chk(brk_b, brk_exp(s, ee), "brake b");
        chk(alarm, (s == 3) ? 8'h37 : 8'h00, "alarm code");
      end
    end
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0000);
    cmd <= 2'h3;
    repeat (8) @(posedge clk_i);
    cmd <= 2'h2;
    repeat (4) begin
      @(posedge clk_i);
      chk(brk_a, 1'b1, "one axis off keeps release");
    end
    cmd <= 2'h0;
    repeat (8) @(posedge clk_i);
    cmd <= 2'h1;
    repeat (8) @(posedge clk_i);
    cmd <= 2'h0;
    repeat (4) begin
      @(posedge clk_i);
      chk(brk_a, en[0], "brake with enable");
      chk(drop, 2'h0, "no drop prevention");
    end
    $display("test brake done");
    slow <= 1'b1;
    cmd <= 2'h3;
    repeat (8) @(posedge clk_i);
    estop_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (en !== 2'h0 && n < 10);
    chk(en, 2'h0, "estop all axes off");
    chk(drop, 2'h3, "drop prevention in estop");
    repeat (10) @(posedge clk_i);
    chk(brk_a, 1'b0, "brake engaged in estop");
    rdc(8'h18, 32'h0000_0010, "status in estop");
    estop_n <= 1'b1;
    repeat (12) begin
      @(posedge clk_i);
      if (brk_a === 1'b1) chk(pwr != 2'h0, 1'b1, "release before power");
    end
    chk(brk_a, 1'b1, "release after cancel");
    for (int f = 0; f < 2; f++) begin
      dalarm <= 1'(f == 0);
      pfail <= 1'(f == 1);
      repeat (2) @(posedge clk_i);
      chk(en, 2'h0, "alarm forces servo off");
      chk(drop, 2'h3, "drop prevention in alarm");
      dalarm <= 1'b0;
      pfail <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk(brk_a, 1'b1, "release after alarm");
    end
    $display("test emergency done");
    for (int t = 0; t < 4; t++) begin
      wr(8'h10, (t & 1) ? 32'h0000_4000 : 32'h0000_0000);
      wr(8'h14, (t >> 1) << 5);
      prox <= 1'b1;
      count(nr);
      prox <= 1'b0;
      count(nf);
      chk(nr, (t == 3) ? 1 : 0, "rising edge pulses");
      chk(nf, (t == 1) ? 1 : 0, "falling edge pulses");
      rdc(8'h1C, 32'(t & 1), "event sticky");
      wr(8'h1C, 32'h0000_0001);
      rdc(8'h1C, 32'h0000_0000, "event cleared");
    end
    $display("test proximity done");
    complete_run();
  end
  initial begin
    #100000;
    chk(1'b0, 1'b1, "watchdog expired");
    complete_run();
  end
endmodule // dib_top_bench
